// ---- src/presample_pkg.sv ----
package presample_pkg;
    localparam int unsigned NUM_CHANNELS   = 16;
    localparam int unsigned CH_W           = 4;
    localparam int unsigned PRESAMPLE_CYC  = 8;
    localparam int unsigned SAMPLE_CYC     = 16;
    localparam int unsigned CONVERT_CYC    = 12;
    localparam int unsigned CNT_W          = 8;
    localparam logic        REF_HIGH       = 1'b1;
    localparam logic        REF_LOW        = 1'b0;

    // analog switch selection driven onto the sampling capacitor
    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_REF  = 2'h1,
        SRC_PAD  = 2'h3
    } sample_src_t;

    typedef enum logic [1:0] {
        ST_IDLE      = 2'h0,
        ST_PRESAMPLE = 2'h1,
        ST_SAMPLE    = 2'h3,
        ST_CONVERT   = 2'h2
    } seq_state_t;
endpackage

// ---- src/phase_timer_if.sv ----
`timescale 1ns/1ps
interface phase_timer_if;
    logic                              start;
    logic [presample_pkg::CNT_W-1:0]   length;
    logic                              done;
    modport ctrl  (output start, output length, input done);
    modport timer (input start, input length, output done);
endinterface

// ---- src/phase_timer.sv ----
`timescale 1ns/1ps
module phase_timer (
    input  wire logic clk,
    input  wire logic rst,
    phase_timer_if.timer tmr
);
    logic [presample_pkg::CNT_W-1:0] count;
    logic                            running;

    wire last_cycle = running && (count == 8'h01);

    assign tmr.done = last_cycle;

    always_ff @(posedge clk) begin
        if (rst) begin
            count   <= 8'h00;
            running <= 1'b0;
        end else if (tmr.start) begin
            count   <= tmr.length;
            running <= 1'b1;
        end else if (last_cycle) begin
            running <= 1'b0;
            count   <= 8'h00;
        end else if (running) begin
            count <= count - 8'h01;
        end
    end
endmodule // phase_timer

// ---- src/adc_presample_sequencer.sv ----
`timescale 1ns/1ps
// Summary of operation
// - with presampling on, presample first, then sample (unless bypassed) and convert
// - presampling connects the internal reference, never the pad
// - sampling connects the selected pad through the channel mux
// - conversion digitises whatever was sampled last
// - each channel has its own presample enable
// - reference select picks high reference or low reference
// - bypass 0 samples pad after presample; 1 skips pad, converts ref
// - without pad input enable, pad path stays open
module adc_presample_sequencer #(
    parameter int unsigned NUM_CH = presample_pkg::NUM_CHANNELS,
    parameter int unsigned CH_W   = presample_pkg::CH_W
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              start,
    input  wire logic [CH_W-1:0]   channel,
    input  wire logic [NUM_CH-1:0] presample_channel_enable,
    input  wire logic              presample_reference_select,
    input  wire logic              presample_convert_bypass,
    input  wire logic [NUM_CH-1:0] pad_input_enable,
    input  wire logic              convert_done_in,
    output logic                   busy,
    output logic [1:0]             sample_source,
    output logic                   ref_level,
    output logic [CH_W-1:0]        mux_channel,
    output logic                   pad_connect,
    output logic                   convert_start,
    output logic                   sequence_done,
    output logic                   converted_reference
);
    phase_timer_if tif ();

    phase_timer u_timer (
        .clk (clk),
        .rst (rst),
        .tmr (tif)
    );

    presample_pkg::seq_state_t state;
    presample_pkg::seq_state_t next_state;

    logic [CH_W-1:0] cur_ch;
    logic            cur_pre_en;
    logic            cur_ref;
    logic            cur_bypass;
    // both flop stages of every pad enable synchroniser
    logic [NUM_CH-1:0] pad_en_meta;
    logic [NUM_CH-1:0] pad_en_sync;

    // one bit of a per-channel vector, picked by channel number
    function automatic logic channel_bit(
        input logic [NUM_CH-1:0] vec,
        input logic [CH_W-1:0]   idx
    );
        return vec[idx];
    endfunction

    // length of each timed phase, in clock cycles
    function automatic logic [presample_pkg::CNT_W-1:0] phase_cycles(
        input presample_pkg::seq_state_t phase
    );
        logic [presample_pkg::CNT_W-1:0] cycles;
        cycles = 8'h00;
        unique case (phase)
            presample_pkg::ST_PRESAMPLE: begin
                cycles = 8'(presample_pkg::PRESAMPLE_CYC);
            end
            presample_pkg::ST_SAMPLE: begin
                cycles = 8'(presample_pkg::SAMPLE_CYC);
            end
            presample_pkg::ST_CONVERT: begin
                cycles = 8'(presample_pkg::CONVERT_CYC);
            end
            presample_pkg::ST_IDLE: begin
                cycles = 8'h00;
            end
        endcase
        return cycles;
    endfunction

    wire go           = start && (state == presample_pkg::ST_IDLE);
    wire ch_pre_en = channel_bit(presample_channel_enable, channel);
    wire skip_sample  = cur_pre_en && cur_bypass;
    wire phase_done   = tif.done;

    // channel taken this cycle, otherwise the one in progress
    wire [CH_W-1:0] active_ch = go ? channel : cur_ch;
    // picked after synchronising, so a new channel shows no lag
    wire pad_en_sel   = channel_bit(pad_en_sync, active_ch);

    always_comb begin
        next_state = state;
        unique case (state)
            presample_pkg::ST_IDLE: begin
                if (go) begin
                    next_state = ch_pre_en ? presample_pkg::ST_PRESAMPLE
                                           : presample_pkg::ST_SAMPLE;
                end
            end
            presample_pkg::ST_PRESAMPLE: begin
                if (phase_done) begin
                    next_state = skip_sample ? presample_pkg::ST_CONVERT
                                             : presample_pkg::ST_SAMPLE;
                end
            end
            presample_pkg::ST_SAMPLE: begin
                if (phase_done) begin
                    next_state = presample_pkg::ST_CONVERT;
                end
            end
            presample_pkg::ST_CONVERT: begin
                if (phase_done || convert_done_in) begin
                    next_state = presample_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // phase the sequencer moves into at the next edge
    wire next_is_idle = (next_state == presample_pkg::ST_IDLE);
    wire next_is_pre  = (next_state == presample_pkg::ST_PRESAMPLE);
    wire next_is_samp = (next_state == presample_pkg::ST_SAMPLE);
    wire next_is_conv = (next_state == presample_pkg::ST_CONVERT);

    // an early end leaves the timer running; the next start reloads it
    wire entering   = (next_state != state);
    wire enter_pre  = entering && next_is_pre;
    wire enter_samp = entering && next_is_samp;
    wire enter_conv = entering && next_is_conv;
    wire enter_idle = entering && next_is_idle;

    assign tif.start  = enter_pre || enter_samp || enter_conv;
    assign tif.length = phase_cycles(next_state);

    // source of the capacitor charge in each phase
    wire [1:0] next_source =
        next_is_pre  ? presample_pkg::SRC_REF :
        next_is_samp ? presample_pkg::SRC_PAD :
                       presample_pkg::SRC_NONE;

    wire next_pad_connect = next_is_samp && pad_en_sel;

    // two flops per pad before anything reads the enable
    for (genvar i = 0; i < NUM_CH; i++) begin : g_pad_sync
        always_ff @(posedge clk) begin
            if (rst) begin
                pad_en_meta[i] <= 1'b0;
                pad_en_sync[i] <= 1'b0;
            end else begin
                pad_en_meta[i] <= pad_input_enable[i];
                pad_en_sync[i] <= pad_en_meta[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= presample_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // settings are frozen when a request is taken
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_ch     <= '0;
            cur_pre_en <= 1'b0;
            cur_ref    <= presample_pkg::REF_LOW;
            cur_bypass <= 1'b0;
        end else if (go) begin
            cur_ch     <= channel;
            cur_pre_en <= ch_pre_en;
            cur_ref    <= presample_reference_select;
            cur_bypass <= presample_convert_bypass;
        end
    end

    wire next_busy     = !next_is_idle;
    wire next_ref      = go ? presample_reference_select : cur_ref;
    wire next_conv_ref = enter_conv ? (state == presample_pkg::ST_PRESAMPLE)
                                    : converted_reference;

    // phase indication towards the analog switches
    always_ff @(posedge clk) begin
        if (rst) begin
            busy          <= 1'b0;
            sample_source <= presample_pkg::SRC_NONE;
            pad_connect   <= 1'b0;
        end else begin
            busy          <= next_busy;
            sample_source <= next_source;
            pad_connect   <= next_pad_connect;
        end
    end

    // reference and channel of the sequence in progress
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_level   <= presample_pkg::REF_LOW;
            mux_channel <= '0;
        end else begin
            ref_level   <= next_ref;
            mux_channel <= active_ch;
        end
    end

    // single-cycle pulses and the origin of the last conversion
    // converted_reference holds until the next conversion starts
    always_ff @(posedge clk) begin
        if (rst) begin
            convert_start       <= 1'b0;
            sequence_done       <= 1'b0;
            converted_reference <= 1'b0;
        end else begin
            convert_start       <= enter_conv;
            sequence_done       <= enter_idle;
            converted_reference <= next_conv_ref;
        end
    end
endmodule // adc_presample_sequencer

// ---- tb/adc_presample_sequencer_assertions.sv ----
`timescale 1ns/1ps
module seq_checker #(
    parameter int unsigned CH_W = 4
) (
    input wire logic            clk,
    input wire logic            rst,
    input wire logic            start,
    input wire logic            busy,
    input wire logic [1:0]      sample_source,
    input wire logic [CH_W-1:0] mux_channel,
    input wire logic            pad_connect,
    input wire logic            convert_start,
    input wire logic            sequence_done,
    input wire logic            converted_reference
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_start_sets_busy: assert property (start && !busy |=> busy)
        else $error("busy not raised");
    a_presample_len: assert property (
        $rose(busy) && sample_source == 2'h1
        |-> sample_source == 2'h1 [*8] ##1 sample_source != 2'h1)
        else $error("presample length wrong");
    a_sample_len: assert property (
        sample_source == 2'h3 && $past(sample_source) != 2'h3
        |-> ##15 sample_source == 2'h3 ##1 convert_start)
        else $error("sample length wrong");
    a_pad_in_sample: assert property (
        pad_connect |-> sample_source == 2'h3)
        else $error("pad switch closed outside sampling");
    a_ref_converted: assert property (
        convert_start && $past(sample_source) == 2'h1
        |-> ##[1:12] sequence_done && converted_reference)
        else $error("reference conversion not flagged");
    a_pad_converted: assert property (
        convert_start && $past(sample_source) == 2'h3
        |-> ##[1:12] sequence_done && !converted_reference)
        else $error("pad conversion flagged as reference");
    a_done_idle: assert property (
        sequence_done |-> !busy ##1 !sequence_done)
        else $error("done pulse wrong");
    a_mux_stable: assert property (
        busy && $past(busy) |-> $stable(mux_channel))
        else $error("channel changed in sequence");
    a_idle_open: assert property (
        !busy |-> sample_source == 2'h0 && !pad_connect)
        else $error("switch active while idle");
endmodule // seq_checker
bind adc_presample_sequencer seq_checker #(.CH_W(CH_W)) u_seq_checker (
    .clk(clk), .rst(rst), .start(start), .busy(busy),
    .sample_source(sample_source), .mux_channel(mux_channel),
    .pad_connect(pad_connect), .convert_start(convert_start),
    .sequence_done(sequence_done), .converted_reference(converted_reference));

// ---- tb/tb_adc_presample_sequencer.sv ----
`timescale 1ns/1ps
module tb_adc_presample_sequencer;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic [3:0]  channel = 4'h0;
    logic [15:0] pen = 16'h0000;
    logic [15:0] pad_en = 16'h0000;
    logic        ref_sel = 1'b0;
    logic        bypass = 1'b0;
    logic        early = 1'b0;
    logic        busy, pad_connect, convert_start, sequence_done;
    logic        ref_level, converted_reference;
    logic [1:0]  sample_source;
    logic [3:0]  mux_channel;
    int          err_total = 0;
    int          checked = 0;
    adc_presample_sequencer u_adc_presample_sequencer (
        .clk(clk), .rst(rst), .start(start), .channel(channel),
        .presample_channel_enable(pen), .presample_reference_select(ref_sel),
        .presample_convert_bypass(bypass), .pad_input_enable(pad_en),
        .convert_done_in(early), .busy(busy), .sample_source(sample_source),
        .ref_level(ref_level), .mux_channel(mux_channel),
        .pad_connect(pad_connect), .convert_start(convert_start),
        .sequence_done(sequence_done),
        .converted_reference(converted_reference));
    initial forever #2.5 clk = ~clk;
    task automatic chk(input string what, input logic [7:0] exp, got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // presample enables, reference select and bypass are inverted once the sequence is under way
    task automatic run(input string name, input logic [3:0] ch,
                       input logic pe, rs, bp, pd, cut);
        logic [7:0] p, s, c, pc;
        logic       cs, lv, done;
        p = 8'h00;
        s = 8'h00;
        c = 8'h00;
        pc = 8'h00;
        cs = 1'b0;
        lv = rs;
        done = 1'b0;
        channel = ch;
        pen = pe ? 16'h0001 << ch : ~(16'h0001 << ch);
        pad_en = pd ? 16'h0001 << ch : ~(16'h0001 << ch);
        ref_sel = rs;
        bypass = bp;
        repeat (4) @(posedge clk);
        #1 start = 1'b1;
        for (int i = 0; i < 100 && !done; i++) begin
            @(posedge clk);
            #1;
            early = cut & convert_start;
            if (busy === 1'b1 && start) begin
                start = 1'b0;
                pen = ~pen;
                ref_sel = ~ref_sel;
                bypass = ~bypass;
                chk("mux_channel", ch, mux_channel);
            end
            p += (sample_source === 2'h1);
            s += (sample_source === 2'h3);
            pc += (pad_connect === 1'b1);
            if (sample_source === 2'h1)
                lv = ref_level;
            if (cs)
                c++;
            cs |= (convert_start === 1'b1);
            done = (sequence_done === 1'b1);
        end
        if (!done) begin
            chk("sequence end", 8'h01, 8'h00);
            stop_test();
        end
        chk("presample cycles", pe ? 8'h08 : 8'h00, p);
        chk("sample cycles", pe && bp ? 8'h00 : 8'h10, s);
        chk("pad cycles", pd && !(pe && bp) ? 8'h10 : 8'h00, pc);
        chk("ref_level", rs, lv);
        chk("convert cycles", cut ? 8'h01 : 8'h0C, c);
        chk("converted_reference", pe && bp, converted_reference);
        $display("test %s done", name);
    endtask
    task automatic t_presample_high();
        run("presample high", 4'h3, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    endtask
    task automatic t_bypass_low();
        run("bypass low", 4'hF, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic t_no_presample();
        run("no presample", 4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic t_open_pad();
        run("open pad", 4'h9, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic t_early_end();
        run("early end", 4'h5, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 chk("reset state", 8'h00, {busy, sample_source, convert_start});
        rst = 1'b0;
        t_presample_high();
        t_bypass_low();
        t_no_presample();
        t_open_pad();
        t_early_end();
        stop_test();
    end
endmodule // tb_adc_presample_sequencer
